/* hw/atp_timer.sv */
// atp_timer: 8-bit timer with compare output modes and buffered async
// register writes
// assumes the oscillator pin is sampled in the clk domain and toggles
// more than four times slower than clk
`timescale 1ns/100ps

// What this block does
// - nonzero compare output mode routes the waveform onto the pin
// - non-pwm modes: off, toggle, clear or set on match, field at 5:4
// - fast pwm: 01 reserved, 10 clear match set bottom, 11 inverse
// - fast pwm with compare at top: match ignored, bottom action only
// - phase pwm: 10 clear up-match set down-match, 11 inverse, 01 none
// - phase pwm with compare at top: match ignored, action done at top
// - clock select stops at 000, else divides by 1..1024
// - counter readable and writable; write blocks next compare match
// - compare register matched against counter on every timer clock
// - with async select set, external clock bit enables input buffer; crystal runs when zero
// - async select picks io clock or oscillator pin as timer source
// - async counter write sets counter busy until transfer completes
// - async compare write sets compare busy until transfer completes
// - async control write sets control busy until transfer completes
// - counter read is live; compare and control read temporaries
// - waveform mode bits pick normal, phase pwm, clear-match, fast pwm
// - force strobe applies compare action in non-pwm, reads zero
// - buffered write lands after two oscillator edges, one per register
module atp_timer
    import atp_pkg::*;
(
    input  wire logic       clk,             // 200 MHz system clock
    input  wire logic       arst_n,          // async reset, active low
    input  wire logic [7:0] addr,            // register address
    input  wire logic [7:0] wr_data,         // write data
    input  wire logic       wr_en,           // write strobe
    input  wire logic       rd_en,           // read strobe
    output logic      [7:0] rd_data,         // read data, cycle after rd_en
    input  wire logic       osc_input_pin,   // oscillator pin level
    output logic            waveform_pin,    // compare waveform
    output logic            waveform_pin_en, // waveform overrides port
    output logic            ext_clk_buf_en,  // external clock buffer on
    output logic            crystal_osc_en,  // crystal oscillator on
    output logic            compare_match    // one-cycle match pulse
);

    // ======================================================================
    // register storage
    // ======================================================================
    logic [7:0] ctl_temp;     // control temporary, read back
    logic [7:0] ctl;          // control destination
    logic [7:0] cmp_temp;     // compare temporary, read back
    logic [7:0] cmp_dest;     // compare destination
    logic [7:0] cmp_active;   // compare value used by the matcher
    logic [7:0] cnt_temp;     // counter temporary
    logic [7:0] counter;      // live counter
    logic       external_clock_select;        // external_clock_select
    logic       async_sel;    // async_select
    logic [2:0] busy;         // update busy flags
    logic [2:0] done;         // transfer finishes this cycle
    logic       dir_up;       // phase pwm count direction
    logic       block_match;  // blocks the match after a counter write

    // oscillator pin synchroniser
    logic       osc_s1;
    logic       osc_s2;
    logic       osc_s3;
    logic       osc_rise;

    atp_mode_t  mode;
    logic [1:0] com;
    logic       src_tick;
    logic       count_tick;
    logic       match;
    logic       wr_ctl;
    logic       wr_cmp;
    logic       wr_cnt;
    logic       load_ctl;
    logic [7:0] load_ctl_val;
    logic       load_cnt;
    logic [7:0] load_cnt_val;
    logic       force_now;
    logic [1:0] force_com;
    logic       at_top;

    assign mode = atp_mode_t'({ctl[CTL_WGM_HI], ctl[CTL_WGM_LO]});
    assign com  = ctl[CTL_COM_HI:CTL_COM_LO];

    // write decode
    assign wr_ctl = wr_en && (addr == ADDR_CONTROL);
    assign wr_cmp = wr_en && (addr == ADDR_COMPARE);
    assign wr_cnt = wr_en && (addr == ADDR_COUNTER);

    // ======================================================================
    // oscillator edge detection and timer source
    // ======================================================================
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            osc_s1 <= 1'b0;
            osc_s2 <= 1'b0;
            osc_s3 <= 1'b0;
        end
        else
        begin
            osc_s1 <= osc_input_pin;
            osc_s2 <= osc_s1;
            osc_s3 <= osc_s2;
        end
    end

    assign osc_rise = osc_s2 && !osc_s3;
    assign src_tick = async_sel ? osc_rise : 1'b1;

    atp_prescaler u_prescaler (
        .clk          (clk),
        .arst_n       (arst_n),
        .src_tick     (src_tick),
        .clock_select (ctl[CTL_CS_HI:CTL_CS_LO]),
        .count_tick   (count_tick)
    );

    // ======================================================================
    // update busy flags, one tracker per buffered register
    // ======================================================================
    logic [2:0] start;
    assign start[STS_CTL_UB] = wr_ctl && async_sel;
    assign start[STS_CMP_UB] = wr_cmp && async_sel;
    assign start[STS_CNT_UB] = wr_cnt && async_sel;

    genvar gi;
    generate
        for (gi = 0; gi < 3; gi++)
        begin : g_busy
            logic [1:0] edges;
            // finish on the second oscillator edge after the write
            assign done[gi] = busy[gi] && osc_rise && !start[gi]
                              && (edges == XFER_EDGES - 2'h1);
            // a new write wins over a finishing transfer
            always_ff @(posedge clk or negedge arst_n)
            begin
                if (!arst_n)
                begin
                    busy[gi] <= 1'b0;
                    edges    <= 2'h0;
                end
                else if (start[gi])
                begin
                    busy[gi] <= 1'b1;
                    edges    <= 2'h0;
                end
                else if (!async_sel)
                begin
                    busy[gi] <= 1'b0;
                    edges    <= 2'h0;
                end
                else if (done[gi])
                    busy[gi] <= 1'b0;
                else if (busy[gi] && osc_rise)
                    edges <= edges + 2'h1;
            end
        end
    endgenerate

    // ======================================================================
    // temporaries and status register
    // ======================================================================
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            ctl_temp  <= RST_CONTROL;
            cmp_temp  <= RST_COMPARE;
            cnt_temp  <= RST_COUNTER;
            external_clock_select     <= RST_STATUS[STS_EXTERNAL_CLOCK_SELECT];
            async_sel <= RST_STATUS[STS_ASYNC];
        end
        else
        begin
            if (wr_ctl)
                ctl_temp <= wr_data;
            if (wr_cmp)
                cmp_temp <= wr_data;
            if (wr_cnt)
                cnt_temp <= wr_data;
            if (wr_en && (addr == ADDR_STATUS))
            begin
                external_clock_select     <= wr_data[STS_EXTERNAL_CLOCK_SELECT];
                async_sel <= wr_data[STS_ASYNC];
            end
        end
    end

    // ======================================================================
    // destination loads: direct when synchronous, after transfer otherwise
    // ======================================================================
    assign load_ctl     = (wr_ctl && !async_sel) || done[STS_CTL_UB];
    assign load_ctl_val = done[STS_CTL_UB] ? ctl_temp : wr_data;
    assign load_cnt     = (wr_cnt && !async_sel) || done[STS_CNT_UB];
    assign load_cnt_val = done[STS_CNT_UB] ? cnt_temp : wr_data;

    // force strobe only in the non-pwm modes, using the loaded mode bits
    assign force_com = load_ctl_val[CTL_COM_HI:CTL_COM_LO];
    assign force_now = load_ctl && load_ctl_val[CTL_FORCE]
                       && !load_ctl_val[CTL_WGM_LO];

    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            ctl      <= RST_CONTROL;
            cmp_dest <= RST_COMPARE;
        end
        else
        begin
            if (load_ctl)
                ctl <= {1'b0, load_ctl_val[6:0]};
            if (wr_cmp && !async_sel)
                cmp_dest <= wr_data;
            else if (done[STS_CMP_UB])
                cmp_dest <= cmp_temp;
        end
    end

    // double buffered compare: immediate in non-pwm, at top only else
    assign at_top = count_tick && (counter == COUNT_MAX);
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
            cmp_active <= RST_COMPARE;
        else if (mode == ATP_NORMAL || mode == ATP_CLEAR_MATCH || at_top)
            cmp_active <= cmp_dest;
    end

    // ======================================================================
    // counter and direction
    // ======================================================================
    assign match = count_tick && !block_match
                   && (counter == cmp_active);

    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            counter <= RST_COUNTER;
            dir_up  <= 1'b1;
        end
        else if (load_cnt)
            counter <= load_cnt_val;
        else if (count_tick)
        begin
            case (mode)
                ATP_CLEAR_MATCH:
                    counter <= (counter == cmp_active) ? COUNT_BOT
                               : counter + 8'h01;
                ATP_PHASE_PWM:
                begin
                    if (dir_up && counter == COUNT_MAX)
                    begin
                        counter <= counter - 8'h01;
                        dir_up  <= 1'b0;
                    end
                    else if (!dir_up && counter == COUNT_BOT)
                    begin
                        counter <= counter + 8'h01;
                        dir_up  <= 1'b1;
                    end
                    else if (dir_up)
                        counter <= counter + 8'h01;
                    else
                        counter <= counter - 8'h01;
                end
                default:
                    counter <= counter + 8'h01;
            endcase
        end
    end

    // a counter write removes the match on the following timer clock
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
            block_match <= 1'b0;
        else if (load_cnt)
            block_match <= 1'b1;
        else if (count_tick)
            block_match <= 1'b0;
    end

    // ======================================================================
    // waveform generation
    // ======================================================================
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
            waveform_pin <= 1'b0;
        else if (force_now)
        begin
            case (force_com)
                COM_TOGGLE: waveform_pin <= !waveform_pin;
                COM_CLEAR:  waveform_pin <= 1'b0;
                COM_SET:    waveform_pin <= 1'b1;
                default:    waveform_pin <= waveform_pin;
            endcase
        end
        else
        begin
            case (mode)
                ATP_FAST_PWM:
                begin
                    if (at_top && com[1])
                        waveform_pin <= !com[0];
                    else if (match && com[1])
                        waveform_pin <= com[0];
                end
                ATP_PHASE_PWM:
                begin
                    if (at_top && com[1] && cmp_active == COUNT_MAX)
                        waveform_pin <= !com[0];
                    else if (match && com[1])
                        waveform_pin <= dir_up ? com[0] : !com[0];
                end
                default:
                begin
                    if (match)
                    begin
                        case (com)
                            COM_TOGGLE: waveform_pin <= !waveform_pin;
                            COM_CLEAR:  waveform_pin <= 1'b0;
                            COM_SET:    waveform_pin <= 1'b1;
                            default:    waveform_pin <= waveform_pin;
                        endcase
                    end
                end
            endcase
        end
    end

    // pin override and oscillator controls
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            waveform_pin_en <= 1'b0;
            ext_clk_buf_en  <= 1'b0;
            crystal_osc_en  <= 1'b0;
            compare_match   <= 1'b0;
        end
        else
        begin
            waveform_pin_en <= (com != COM_OFF);
            ext_clk_buf_en  <= external_clock_select && async_sel;
            crystal_osc_en  <= !external_clock_select && async_sel;
            compare_match   <= match;
        end
    end

    // ======================================================================
    // read port
    // ======================================================================
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
            rd_data <= 8'h00;
        else if (!rd_en)
            rd_data <= 8'h00;
        else if (addr == ADDR_COUNTER)
            rd_data <= counter;
        else if (addr == ADDR_COMPARE)
            rd_data <= cmp_temp;
        else if (addr == ADDR_CONTROL)
            rd_data <= {1'b0, ctl_temp[6:0]};
        else if (addr == ADDR_STATUS)
            rd_data <= {3'h0, external_clock_select, async_sel, busy};
        else
            rd_data <= 8'h00;
    end

    // ======================================================================
    // assertions
    // ======================================================================
    default clocking cb @(posedge clk); endclocking
    default disable iff (!arst_n);

    sync_busy_a: assert property (!async_sel |=> busy == 3'h0)
        else $error("busy flag set while synchronous");
    cmp_busy_a: assert property (wr_cmp && async_sel |=> busy[1])
        else $error("compare busy not set by async write");
    cnt_load_a: assert property (wr_cnt && !async_sel
                                 |=> counter == $past(wr_data))
        else $error("synchronous counter write not applied");
    force_read_a: assert property (rd_en && addr == ADDR_CONTROL
                                   |=> !rd_data[7])
        else $error("force strobe reads as one");
    cmp_read_a: assert property (rd_en && addr == ADDR_COMPARE
                                 |=> rd_data == $past(cmp_temp))
        else $error("compare read not from temporary");
    pin_override_a: assert property (1'b1 |=> waveform_pin_en
                                     == ($past(com) != 2'h0))
        else $error("pin override does not follow mode");
    block_match_a: assert property (block_match && count_tick
                                    && counter == cmp_active
                                    |=> !compare_match)
        else $error("match not blocked after counter write");
    stop_clock_a: assert property (ctl[2:0] == 3'h0
                                   |-> !count_tick)
        else $error("counter advanced while stopped");
    ext_buf_a: assert property (1'b1 |=> ext_clk_buf_en
                                == $past(external_clock_select && async_sel))
        else $error("external buffer enable wrong");
    toggle_a: assert property (match && !ctl[CTL_WGM_LO]
                               && com == COM_TOGGLE && !force_now
                               |=> waveform_pin != $past(waveform_pin))
        else $error("toggle on match missing");

endmodule : atp_timer

/* hw/atp_pkg.sv */
// atp_pkg: constants shared by the asynchronous timer/pwm control block
// assumes an 8-bit register port and a single system clock
package atp_pkg;

    // ======================================================================
    // register offsets
    // ======================================================================
    localparam logic [7:0] ADDR_CONTROL = 8'hb0; // timer_control
    localparam logic [7:0] ADDR_COUNTER = 8'hb2; // counter_value
    localparam logic [7:0] ADDR_COMPARE = 8'hb3; // compare_value
    localparam logic [7:0] ADDR_STATUS  = 8'hb6; // async_clock_status

    // ======================================================================
    // timer_control fields
    // ======================================================================
    localparam int CTL_FORCE   = 7; // force_compare_strobe
    localparam int CTL_WGM_LO  = 6; // waveform_mode_bits[0]
    localparam int CTL_COM_HI  = 5; // compare_output_mode[1]
    localparam int CTL_COM_LO  = 4; // compare_output_mode[0]
    localparam int CTL_WGM_HI  = 3; // waveform_mode_bits[1]
    localparam int CTL_CS_HI   = 2; // clock_select_field msb
    localparam int CTL_CS_LO   = 0; // clock_select_field lsb

    // ======================================================================
    // async_clock_status fields
    // ======================================================================
    localparam int STS_EXTERNAL_CLOCK_SELECT   = 4; // external_clock_select
    localparam int STS_ASYNC   = 3; // async_select
    localparam int STS_CNT_UB  = 2; // counter_update_busy
    localparam int STS_CMP_UB  = 1; // compare_update_busy
    localparam int STS_CTL_UB  = 0; // control_update_busy

    // ======================================================================
    // reset values and counter limits
    // ======================================================================
    localparam logic [7:0] RST_CONTROL = 8'h00;
    localparam logic [7:0] RST_COUNTER = 8'h00;
    localparam logic [7:0] RST_COMPARE = 8'h00;
    localparam logic [7:0] RST_STATUS  = 8'h00;
    localparam logic [7:0] COUNT_MAX   = 8'hff;
    localparam logic [7:0] COUNT_BOT   = 8'h00;

    // oscillator edges before a buffered write lands
    localparam logic [1:0] XFER_EDGES  = 2'h2;
    localparam int         PRE_WIDTH   = 10;

    // ======================================================================
    // modes and compare output actions
    // ======================================================================
    typedef enum logic [1:0] {
        ATP_NORMAL,
        ATP_PHASE_PWM,
        ATP_CLEAR_MATCH,
        ATP_FAST_PWM
    } atp_mode_t;

    localparam logic [1:0] COM_OFF    = 2'h0;
    localparam logic [1:0] COM_TOGGLE = 2'h1;
    localparam logic [1:0] COM_CLEAR  = 2'h2;
    localparam logic [1:0] COM_SET    = 2'h3;

    // prescaler masks for clock_select_field 2..7
    localparam logic [9:0] DIV8_MASK    = 10'h007;
    localparam logic [9:0] DIV32_MASK   = 10'h01f;
    localparam logic [9:0] DIV64_MASK   = 10'h03f;
    localparam logic [9:0] DIV128_MASK  = 10'h07f;
    localparam logic [9:0] DIV256_MASK  = 10'h0ff;
    localparam logic [9:0] DIV1024_MASK = 10'h3ff;

endpackage : atp_pkg

/* hw/atp_prescaler.sv */
// atp_prescaler: divides the timer source tick by the selected factor
// assumes src_tick is a one-cycle enable in the clk domain
`timescale 1ns/100ps
module atp_prescaler
    import atp_pkg::*;
(
    input  wire logic       clk,          // system clock
    input  wire logic       arst_n,       // async reset, active low
    input  wire logic       src_tick,     // one tick of timer_source_clock
    input  wire logic [2:0] clock_select, // clock_select_field
    output logic            count_tick    // counter advance enable
);

    // ======================================================================
    // free running prescale counter
    // ======================================================================
    logic [PRE_WIDTH-1:0] pre;
    logic [PRE_WIDTH-1:0] mask;

    // advance on every source tick
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
            pre <= '0;
        else if (src_tick)
            pre <= pre + 1'b1;
    end

    // mask of low bits that must be all ones for a tick
    always_comb
    begin
        mask = '0;
        case (clock_select)
            3'h2: mask = DIV8_MASK;
            3'h3: mask = DIV32_MASK;
            3'h4: mask = DIV64_MASK;
            3'h5: mask = DIV128_MASK;
            3'h6: mask = DIV256_MASK;
            3'h7: mask = DIV1024_MASK;
            default: mask = '0;
        endcase
    end

    // zero select stops the counter
    assign count_tick = src_tick && (clock_select != 3'h0)
                        && ((pre & mask) == mask);

endmodule : atp_prescaler

/* verification/atp_osc_model.sv */
// atp_osc_model: slow oscillator standing at the timer pin
// assumes run comes from the timer's oscillator enables
`timescale 1ns/100ps
module atp_osc_model (
    input  wire logic run, // crystal or external buffer on
    output logic      pin  // oscillator level
);
    // free-running square wave while enabled, low when stopped
    initial
    begin
        pin = 1'b0;
        forever #25 pin = run ? ~pin : 1'b0;
    end
endmodule : atp_osc_model

/* verification/test_async_timer_pwm_control.sv */
// test_async_timer_pwm_control: bus-level tests of the timer block
// assumes atp_pkg constants and the oscillator model beside it
`timescale 1ns/100ps
`define CHK(n, e, g) begin samples_checked++; if ((g) !== (e)) begin \
err_total++; $display("mismatch %s exp %h got %h", n, e, g); end end
module test_async_timer_pwm_control
    import atp_pkg::*;
;
    logic       clk, arst_n, wr_en, rd_en, osc;
    logic [7:0] addr, wr_data, rd_data, d;
    logic       pin, pin_en, ext_en, xtal_en, match;
    int         err_total, samples_checked, k, n;
    logic [7:0] frc [4] = '{8'hb0, 8'ha0, 8'h90, 8'h90};
    logic       fpin[4] = '{1'b1, 1'b0, 1'b1, 1'b0};
    logic [7:0] ra  [3] = '{ADDR_CONTROL, ADDR_COUNTER, ADDR_COMPARE};
    logic [7:0] rv  [3] = '{8'h10, 8'h33, 8'h44};
    int         rb  [3] = '{STS_CTL_UB, STS_CNT_UB, STS_CMP_UB};
    // =========
    // clock
    initial
    begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end
    atp_timer i_atp_timer (.clk(clk), .arst_n(arst_n), .addr(addr),
        .wr_data(wr_data), .wr_en(wr_en), .rd_en(rd_en),
        .rd_data(rd_data), .osc_input_pin(osc), .waveform_pin(pin),
        .waveform_pin_en(pin_en), .ext_clk_buf_en(ext_en),
        .crystal_osc_en(xtal_en), .compare_match(match));
    atp_osc_model i_atp_osc_model (.run(ext_en | xtal_en), .pin(osc));
    // =========
    // bus tasks
    task automatic wr(input logic [7:0] a, input logic [7:0] v);
        @(posedge clk);
        addr    <= a;
        wr_data <= v;
        wr_en   <= 1'b1;
        @(posedge clk);
        wr_en   <= 1'b0;
    endtask : wr
    task automatic rd(input logic [7:0] a);
        @(posedge clk);
        addr  <= a;
        rd_en <= 1'b1;
        @(posedge clk);
        rd_en <= 1'b0;
        #1 d = rd_data;
    endtask : rd
    task automatic conclude;
        $display("checks %0d mismatches %0d", samples_checked, err_total);
        if (err_total == 0 && samples_checked > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask : conclude
    // poll a busy flag with a bound; software waits before rewriting
    task automatic wait_idle(input int b);
        for (n = 0; n < 200 && d[b] !== 1'b0; n++)
            rd(ADDR_STATUS);
        if (n == 200)
        begin
            err_total++;
            conclude();
        end
    endtask : wait_idle
    // =========
    // main sequence
    initial
    begin
        {arst_n, wr_en, rd_en, addr, wr_data} = '0;
        err_total = 0;
        samples_checked = 0;
        repeat (8) @(posedge clk);
        arst_n <= 1'b1;
        rd(ADDR_STATUS);
        `CHK("status", RST_STATUS, d)
        rd(8'h55);
        `CHK("unmapped", 8'h00, d)
        wr(ADDR_COUNTER, 8'h5a);
        rd(ADDR_COUNTER);
        `CHK("count", 8'h5a, d)
        $display("test reset_sync done");
        for (k = 0; k < 4; k++)
        begin
            wr(ADDR_CONTROL, frc[k]);
            repeat (2) @(posedge clk);
            #1 `CHK("force_pin", fpin[k], pin)
        end
        `CHK("pin_en", 1'b1, pin_en)
        rd(ADDR_CONTROL);
        `CHK("ctl_read", 8'h10, d)
        rd(ADDR_STATUS);
        `CHK("sync_busy", 8'h00, d)
        $display("test force done");
        wr(ADDR_COMPARE, 8'h20);
        wr(ADDR_COUNTER, 8'h00);
        wr(ADDR_CONTROL, 8'h31);
        for (n = 0; n < 300 && match !== 1'b1; n++)
            @(posedge clk);
        if (n == 300)
        begin
            err_total++;
            conclude();
        end
        repeat (2) @(posedge clk);
        #1 `CHK("match_pin", 1'b1, pin)
        wr(ADDR_COMPARE, 8'hff);
        wr(ADDR_CONTROL, 8'h79);
        repeat (600) @(posedge clk);
        for (n = 0, k = 0; n < 300; n++)
            @(negedge clk) k += pin;
        `CHK("fast_top", 0, k)
        wr(ADDR_CONTROL, 8'h00);
        @(posedge clk);
        #1 `CHK("pin_off", 1'b0, pin_en)
        $display("test match done");
        // clear on match, toggle: 17-tick half period, 20 halves sampled
        wr(ADDR_COMPARE, 8'h10);
        wr(ADDR_COUNTER, 8'h00);
        wr(ADDR_CONTROL, 8'h19);
        for (n = 0, k = 0; n < 340; n++)
            @(negedge clk) k += pin;
        `CHK("ctc_toggle", 170, k)
        // phase pwm, compare 0x40: high 128 of every 510 ticks
        wr(ADDR_COMPARE, 8'h40);
        wr(ADDR_COUNTER, 8'h00);
        wr(ADDR_CONTROL, 8'h61);
        repeat (100) @(posedge clk);
        for (n = 0, k = 0; n < 1020; n++)
            @(negedge clk) k += pin;
        `CHK("phase_pwm", 256, k)
        // divide by 8: ten ticks in 80 clocks, first match blocked
        wr(ADDR_CONTROL, 8'h02);
        wr(ADDR_COUNTER, 8'h40);
        repeat (79) @(posedge clk);
        rd(ADDR_COUNTER);
        `CHK("div8", 8'h4a, d)
        $display("test modes done");
        wr(ADDR_STATUS, 8'h10);
        wr(ADDR_STATUS, 8'h18);
        @(posedge clk);
        #1 `CHK("ext_buf", 2'b10, {ext_en, xtal_en})
        for (k = 0; k < 3; k++)
        begin
            wr(ra[k], rv[k]);
            rd(ADDR_STATUS);
            `CHK("busy_set", 1'b1, d[rb[k]])
            wait_idle(rb[k]);
            rd(ra[k]);
            `CHK("async_read", rv[k], d)
        end
        wr(ADDR_STATUS, 8'h08);
        @(posedge clk);
        #1 `CHK("crystal", 2'b01, {ext_en, xtal_en})
        $display("test async done");
        conclude();
    end
endmodule : test_async_timer_pwm_control
